// ==== logic/radio_cmd_consts.svh ====
// Named constants for the radio command decoder
`ifndef RADIO_CMD_CONSTS_SVH
`define RADIO_CMD_CONSTS_SVH

// ----------------------------------------
// Radio controller command codes
// ----------------------------------------
`define CMD_SYNC_CODE 8'ha2
`define CMD_GO_OFF 8'hb0
`define CMD_GO_ON 8'hb1
`define CMD_GO_RX 8'hb2
`define CMD_GO_TX 8'hb5
`define CMD_GO_SLEEP 8'hba
`define CMD_LOAD_CFG 8'hbb
`define CMD_SIG_STRENGTH 8'hbc
`define CMD_IMAGE_CAL 8'hbd
`define CMD_IF_CAL 8'hbe
`define CMD_LOAD_INIT 8'hbf
`define CMD_LOAD_DONE 8'hc7
`define CMD_FULL_RESET 8'hc8
`define CMD_OPT_ENC 8'hd0
`define CMD_OPT_SETUP 8'hd1
`define CMD_OPT_DEC 8'hd2

// ----------------------------------------
// Memory access, registers, status, serial slave
// ----------------------------------------
`define OPC_MEM_WR 5'h03
`define OPC_MEM_RD 5'h07
`define ADDR_MODE_CTL 11'h11a
`define ADDR_PIN_SEL 11'h139
`define ADDR_STEP 11'h001
`define MODE_PA_BIT 0
`define MODE_LNA_BIT 1
`define MODE_SPORT_BIT 2
`define PIN_SEL_BIT 0
`define MODE_CTL_RESET 8'h00
`define PIN_SEL_RESET 8'h00
`define UNMAPPED_READ 8'h00
`define STAT_CODE_OFF 3'h0
`define STAT_CODE_ON 3'h1
`define STAT_CODE_RX 3'h2
`define STAT_CODE_TX 3'h3
`define STAT_CODE_SLEEP 3'h4
`define SPI_LAST_BIT 3'h7

`endif

// ==== logic/radio_cmd_pkg.sv ====
// Types shared by the radio command decoder files
package radio_cmd_pkg;

   typedef enum logic [4:0] {
      OFF_STATE = 5'h01,
      ON_STATE = 5'h02,
      RECEIVE_STATE = 5'h04,
      TRANSMIT_STATE = 5'h08,
      SLEEP_STATE = 5'h10
   } radio_state_t;

   typedef enum logic [3:0] {
      DEC_IDLE = 4'h1,
      DEC_ADDR = 4'h2,
      DEC_WDATA = 4'h4,
      DEC_RDATA = 4'h8
   } dec_state_t;

   typedef struct packed {
      logic sync_done;
      logic load_config;
      logic signal_strength;
      logic if_filter_cal;
      logic image_cal;
      logic full_reset;
      logic load_init;
      logic cp_reset;
      logic encrypt;
      logic decrypt_setup;
      logic decrypt;
      logic fec_encode_setup;
      logic fec_encode;
      logic fec_decode;
   } op_strobe_t;

   typedef struct packed {
      logic pa;
      logic lna;
   } amp_ctl_t;

endpackage : radio_cmd_pkg

// ==== logic/spi_byte_slave.sv ====
// Byte-wide serial slave, mode 0, MSB first, pins synchronised to clk_sys_in
`timescale 1ns/1ps
`include "radio_cmd_consts.svh"

module spi_byte_slave (
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   input wire logic sclk_in,
   input wire logic mosi_in,
   input wire logic cs_n_in,
   input wire logic [7:0] reply_in,
   output logic byte_valid_out,
   output logic [7:0] byte_out,
   output logic frame_start_out,
   output logic frame_end_out,
   output logic miso_out,
   output logic miso_oe_out
);

   // ----------------------------------------
   // Pin synchronisers: {sclk, mosi, cs_n}
   // ----------------------------------------
   logic [2:0] meta_q;
   logic [2:0] sync_q;
   logic [1:0] prev_q;
   logic [2:0] bit_cnt_q;
   logic [7:0] rx_sh_q;
   logic [7:0] tx_sh_q;
   logic reload_q;

   wire sclk_s = sync_q[2];
   wire mosi_s = sync_q[1];
   wire cs_n_s = sync_q[0];
   wire sclk_rise = sclk_s & ~prev_q[1] & ~cs_n_s;
   wire sclk_fall = ~sclk_s & prev_q[1] & ~cs_n_s;
   wire cs_fall = ~cs_n_s & prev_q[0];
   wire cs_rise = cs_n_s & ~prev_q[0];
   wire byte_done = sclk_rise & (bit_cnt_q == `SPI_LAST_BIT);
   wire [7:0] rx_next = {rx_sh_q[6:0], mosi_s};

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         meta_q <= 3'h1;
         sync_q <= 3'h1;
         prev_q <= 2'h1;
      end else begin
         meta_q <= {sclk_in, mosi_in, cs_n_in};
         sync_q <= meta_q;
         prev_q <= {sync_q[2], sync_q[0]};
      end
   end

   // ----------------------------------------
   // Shift registers
   // ----------------------------------------
   // The reply is taken one cycle after the byte completes so that the
   // decoder can answer from the byte it has just seen.
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         bit_cnt_q <= 3'h0;
         rx_sh_q <= 8'h00;
         tx_sh_q <= 8'h00;
         reload_q <= 1'b0;
         byte_valid_out <= 1'b0;
         byte_out <= 8'h00;
         frame_start_out <= 1'b0;
         frame_end_out <= 1'b0;
         miso_out <= 1'b0;
         miso_oe_out <= 1'b0;
      end else begin
         byte_valid_out <= byte_done;
         frame_start_out <= cs_fall;
         frame_end_out <= cs_rise;
         miso_oe_out <= ~cs_n_s;
         if (cs_n_s) begin
            bit_cnt_q <= 3'h0;
         end else if (sclk_rise) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            rx_sh_q <= rx_next;
         end
         if (byte_done) begin
            byte_out <= rx_next;
         end
         if (cs_fall) begin
            tx_sh_q <= reply_in;
            miso_out <= reply_in[7];
            reload_q <= 1'b0;
         end else if (byte_valid_out) begin
            tx_sh_q <= reply_in;
            reload_q <= 1'b1;
         end else if (sclk_fall) begin
            if (reload_q) begin
               miso_out <= tx_sh_q[7];
               reload_q <= 1'b0;
            end else begin
               tx_sh_q <= {tx_sh_q[6:0], 1'b0};
               miso_out <= tx_sh_q[6];
            end
         end
      end
   end

endmodule : spi_byte_slave

// ==== logic/amp_pin_router.sv ====
// Routes the external amplifier controls to one of two pin pairs
`timescale 1ns/1ps

module amp_pin_router (
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   input wire radio_cmd_pkg::amp_ctl_t ctl_in,
   input wire logic use_test_bus_in,
   output logic test_bus_pin_three_out,
   output logic test_bus_pin_three_oe_out,
   output logic test_bus_pin_four_out,
   output logic test_bus_pin_four_oe_out,
   output logic slow_osc_pin_pos_out,
   output logic slow_osc_pin_pos_oe_out,
   output logic slow_osc_pin_neg_out,
   output logic slow_osc_pin_neg_oe_out
);

   // Unselected pair is released so the oscillator or test bus keeps it
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         test_bus_pin_three_out <= 1'b0;
         test_bus_pin_three_oe_out <= 1'b0;
         test_bus_pin_four_out <= 1'b0;
         test_bus_pin_four_oe_out <= 1'b0;
         slow_osc_pin_pos_out <= 1'b0;
         slow_osc_pin_pos_oe_out <= 1'b0;
         slow_osc_pin_neg_out <= 1'b0;
         slow_osc_pin_neg_oe_out <= 1'b0;
      end else begin
         test_bus_pin_three_out <= use_test_bus_in & ctl_in.pa; // RQ5
         test_bus_pin_three_oe_out <= use_test_bus_in; // RQ5
         test_bus_pin_four_out <= use_test_bus_in & ctl_in.lna; // RQ5
         test_bus_pin_four_oe_out <= use_test_bus_in; // RQ5
         slow_osc_pin_pos_out <= ~use_test_bus_in & ctl_in.pa; // RQ5
         slow_osc_pin_pos_oe_out <= ~use_test_bus_in; // RQ5
         slow_osc_pin_neg_out <= ~use_test_bus_in & ctl_in.lna; // RQ5
         slow_osc_pin_neg_oe_out <= ~use_test_bus_in; // RQ5
      end
   end

endmodule : amp_pin_router

// ==== logic/radio_command_decoder_pa_lna_ctl.sv ====
// Radio command decoder with external amplifier control and host pin muxing
//
// Operation
// RQ1: Packet mode uses only the serial port and the packet interrupt pin.
// RQ2: Sport mode moves data on three serial pins, interrupt on its own pin.
// RQ3: Power-amp enable set: amp control high in transmit state only.
// RQ4: Receive-amp enable set: receive amp control high in receive state only.
// RQ5: Pin select 1 uses test-bus pins, 0 uses slow oscillator pins.
// RQ6: Host sends sync code after reset; device then becomes synchronised.
// RQ7: Code b0 goes to off state, b1 goes to on state.
// RQ8: Code b2 goes to receive state, b5 goes to transmit state.
// RQ9: Code ba goes to sleep state.
// RQ10: Code bb loads radio parameters from battery-backed memory.
// RQ11: Code bc performs one signal strength measurement.
// RQ12: Code be calibrates the intermediate-frequency filter.
// RQ13: Code c8 fully resets hardware, leaving the device asleep.
// RQ14: Code bf opens program memory for a firmware download.
// RQ15: Code c7 resets the processor after a firmware download.
// RQ16: Code bd starts image calibration, only with its firmware loaded.
// RQ17: Cipher module: d0 encrypts, d1 sets up decryption, d2 decrypts.
// RQ18: Error-correction module: d1 sets up, d0 encodes, d2 corrects.
// RQ19: Cipher codes act only when the cipher firmware is loaded.
// RQ20: Error-correction codes act only when that firmware is loaded.
// RQ21: Host sends ff as filler when polling status or reading.
// RQ22: Unknown codes, or codes lacking firmware, leave the state unchanged.
`timescale 1ns/1ps
`include "radio_cmd_consts.svh"

module radio_command_decoder_pa_lna_ctl (
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   input wire logic spi_sclk_in,
   input wire logic spi_mosi_in,
   input wire logic spi_cs_n_in,
   output logic spi_miso_out,
   output logic spi_miso_oe_out,
   input wire logic irq_req_in,
   input wire logic ir_cal_fw_loaded_in,
   input wire logic aes_fw_loaded_in,
   input wire logic fec_fw_loaded_in,
   input wire logic rx_bit_in,
   input wire logic bit_clk_in,
   input wire logic serial_data_pin_c_in,
   output logic serial_data_pin_a_out,
   output logic serial_data_pin_a_oe_out,
   output logic serial_data_pin_b_out,
   output logic serial_data_pin_b_oe_out,
   output logic tx_bit_out,
   output logic packet_mode_interrupt_pin_out,
   output logic sport_interrupt_pin_out,
   output radio_cmd_pkg::radio_state_t radio_state_out,
   output radio_cmd_pkg::op_strobe_t op_strobe_out,
   output logic prog_ram_open_out,
   output logic synced_out,
   output logic test_bus_pin_three_out,
   output logic test_bus_pin_three_oe_out,
   output logic test_bus_pin_four_out,
   output logic test_bus_pin_four_oe_out,
   output logic slow_osc_pin_pos_out,
   output logic slow_osc_pin_pos_oe_out,
   output logic slow_osc_pin_neg_out,
   output logic slow_osc_pin_neg_oe_out
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic byte_vld;
   logic [7:0] rx_byte;
   logic frame_start;
   logic frame_end;
   logic [7:0] reply_byte;

   radio_cmd_pkg::dec_state_t dec_q;
   radio_cmd_pkg::dec_state_t dec_d;
   radio_cmd_pkg::radio_state_t radio_q;
   radio_cmd_pkg::radio_state_t radio_d;
   radio_cmd_pkg::op_strobe_t strobe_d;
   radio_cmd_pkg::amp_ctl_t amp_ctl;

   logic [10:0] addr_q;
   logic [10:0] addr_d;
   logic [7:0] mode_ctl_q;
   logic [7:0] mode_ctl_d;
   logic [7:0] pin_sel_q;
   logic [7:0] pin_sel_d;
   logic synced_q;
   logic synced_d;
   logic prog_open_q;
   logic prog_open_d;
   logic rd_flag_q;
   logic pin_c_meta_q;
   logic pin_c_sync_q;

   // ----------------------------------------
   // Helper functions
   // ----------------------------------------
   function automatic logic [7:0] reg_read(input logic [10:0] addr, input logic [7:0] mode_val,
                                           input logic [7:0] sel_val);
      return (addr == `ADDR_MODE_CTL) ? mode_val :
             (addr == `ADDR_PIN_SEL) ? sel_val : `UNMAPPED_READ;
   endfunction : reg_read

   function automatic logic [2:0] state_code(input radio_cmd_pkg::radio_state_t st);
      logic [2:0] code;
      code = `STAT_CODE_OFF;
      unique case (st)
         radio_cmd_pkg::OFF_STATE: code = `STAT_CODE_OFF;
         radio_cmd_pkg::ON_STATE: code = `STAT_CODE_ON;
         radio_cmd_pkg::RECEIVE_STATE: code = `STAT_CODE_RX;
         radio_cmd_pkg::TRANSMIT_STATE: code = `STAT_CODE_TX;
         radio_cmd_pkg::SLEEP_STATE: code = `STAT_CODE_SLEEP;
      endcase
      return code;
   endfunction : state_code

   // ----------------------------------------
   // Serial slave
   // ----------------------------------------
   spi_byte_slave u_spi (
      .clk_sys_in(clk_sys_in),
      .nrst_in(nrst_in),
      .sclk_in(spi_sclk_in),
      .mosi_in(spi_mosi_in),
      .cs_n_in(spi_cs_n_in),
      .reply_in(reply_byte),
      .byte_valid_out(byte_vld),
      .byte_out(rx_byte),
      .frame_start_out(frame_start),
      .frame_end_out(frame_end),
      .miso_out(spi_miso_out),
      .miso_oe_out(spi_miso_oe_out)
   );

   // ----------------------------------------
   // Command classification
   // ----------------------------------------
   wire dec_idle = (dec_q == radio_cmd_pkg::DEC_IDLE);
   wire cmd_vld = byte_vld & dec_idle;
   // Radio commands are held off until the host has synchronised
   wire cmd_ok = cmd_vld & synced_q; // RQ6
   wire is_mem_wr = (rx_byte[7:3] == `OPC_MEM_WR);
   wire is_mem_rd = (rx_byte[7:3] == `OPC_MEM_RD);
   wire is_sync = cmd_vld & (rx_byte == `CMD_SYNC_CODE); // RQ6
   wire is_full_reset = cmd_ok & (rx_byte == `CMD_FULL_RESET);
   wire is_enc = cmd_ok & (rx_byte == `CMD_OPT_ENC);
   wire is_setup = cmd_ok & (rx_byte == `CMD_OPT_SETUP);
   wire is_dec = cmd_ok & (rx_byte == `CMD_OPT_DEC);
   wire [10:0] addr_inc = addr_q + `ADDR_STEP;
   wire [10:0] addr_first = {addr_q[10:8], rx_byte};

   // ----------------------------------------
   // Radio state transitions
   // ----------------------------------------
   always_comb begin
      radio_d = radio_q;
      if (is_full_reset) begin
         radio_d = radio_cmd_pkg::SLEEP_STATE; // RQ13
      end else if (cmd_ok) begin
         unique case (rx_byte)
            `CMD_GO_OFF: radio_d = radio_cmd_pkg::OFF_STATE; // RQ7
            `CMD_GO_ON: radio_d = radio_cmd_pkg::ON_STATE; // RQ7
            `CMD_GO_RX: radio_d = radio_cmd_pkg::RECEIVE_STATE; // RQ8
            `CMD_GO_TX: radio_d = radio_cmd_pkg::TRANSMIT_STATE; // RQ8
            `CMD_GO_SLEEP: radio_d = radio_cmd_pkg::SLEEP_STATE; // RQ9
            default: radio_d = radio_q; // RQ22
         endcase
      end
   end

   // ----------------------------------------
   // Operation strobes
   // ----------------------------------------
   always_comb begin
      strobe_d.sync_done = is_sync; // RQ6
      strobe_d.load_config = cmd_ok & (rx_byte == `CMD_LOAD_CFG); // RQ10
      strobe_d.signal_strength = cmd_ok & (rx_byte == `CMD_SIG_STRENGTH); // RQ11
      strobe_d.if_filter_cal = cmd_ok & (rx_byte == `CMD_IF_CAL); // RQ12
      strobe_d.full_reset = is_full_reset; // RQ13
      strobe_d.load_init = cmd_ok & (rx_byte == `CMD_LOAD_INIT); // RQ14
      strobe_d.cp_reset = cmd_ok & (rx_byte == `CMD_LOAD_DONE); // RQ15
      strobe_d.image_cal = cmd_ok & (rx_byte == `CMD_IMAGE_CAL) & ir_cal_fw_loaded_in; // RQ16
      strobe_d.encrypt = is_enc & aes_fw_loaded_in; // RQ17 RQ19
      strobe_d.decrypt_setup = is_setup & aes_fw_loaded_in; // RQ17 RQ19
      strobe_d.decrypt = is_dec & aes_fw_loaded_in; // RQ17 RQ19
      strobe_d.fec_encode_setup = is_setup & fec_fw_loaded_in; // RQ18 RQ20
      strobe_d.fec_encode = is_enc & fec_fw_loaded_in; // RQ18 RQ20
      strobe_d.fec_decode = is_dec & fec_fw_loaded_in; // RQ18 RQ20
   end

   // ----------------------------------------
   // Sync and download flags
   // ----------------------------------------
   assign synced_d = ~is_full_reset & (synced_q | is_sync); // RQ6 RQ13
   assign prog_open_d = ~is_full_reset & // RQ13
                        (strobe_d.load_init | (prog_open_q & ~strobe_d.cp_reset)); // RQ14 RQ15

   // ----------------------------------------
   // Memory access sequencer
   // ----------------------------------------
   // Filler bytes during a read only advance the address; their value is ignored
   always_comb begin
      dec_d = dec_q;
      addr_d = addr_q;
      mode_ctl_d = mode_ctl_q;
      pin_sel_d = pin_sel_q;
      if (frame_end || frame_start) begin
         dec_d = radio_cmd_pkg::DEC_IDLE;
      end else if (byte_vld) begin
         unique case (dec_q)
            radio_cmd_pkg::DEC_IDLE: begin
               if (is_mem_wr || is_mem_rd) begin
                  addr_d = {rx_byte[2:0], 8'h00};
                  dec_d = radio_cmd_pkg::DEC_ADDR;
               end
            end
            radio_cmd_pkg::DEC_ADDR: begin
               addr_d = addr_first;
               dec_d = rd_flag_q ? radio_cmd_pkg::DEC_RDATA : radio_cmd_pkg::DEC_WDATA;
            end
            radio_cmd_pkg::DEC_WDATA: begin
               if (addr_q == `ADDR_MODE_CTL) begin
                  mode_ctl_d = rx_byte;
               end else if (addr_q == `ADDR_PIN_SEL) begin
                  pin_sel_d = rx_byte;
               end
               addr_d = addr_inc;
            end
            radio_cmd_pkg::DEC_RDATA: begin
               addr_d = addr_inc; // RQ21
            end
         endcase
      end
   end

   // ----------------------------------------
   // Reply byte: register data while reading, status otherwise
   // ----------------------------------------
   wire [7:0] status_byte = {1'b1, synced_q, 3'h0, state_code(radio_q)};
   wire in_addr = (dec_q == radio_cmd_pkg::DEC_ADDR);
   // The byte loaded now goes out next, so it reads one address ahead
   wire [10:0] rd_addr = in_addr ? addr_first : addr_inc;
   wire rd_active = (in_addr & rd_flag_q) | (dec_q == radio_cmd_pkg::DEC_RDATA);
   assign reply_byte = rd_active ? reg_read(rd_addr, mode_ctl_q, pin_sel_q) : status_byte;

   // ----------------------------------------
   // State registers
   // ----------------------------------------
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         dec_q <= radio_cmd_pkg::DEC_IDLE;
         addr_q <= 11'h000;
         rd_flag_q <= 1'b0;
         radio_q <= radio_cmd_pkg::SLEEP_STATE;
         mode_ctl_q <= `MODE_CTL_RESET;
         pin_sel_q <= `PIN_SEL_RESET;
         synced_q <= 1'b0;
         prog_open_q <= 1'b0;
         op_strobe_out <= '0;
         radio_state_out <= radio_cmd_pkg::SLEEP_STATE;
         prog_ram_open_out <= 1'b0;
         synced_out <= 1'b0;
      end else begin
         dec_q <= dec_d;
         addr_q <= addr_d;
         if (cmd_vld) begin
            rd_flag_q <= is_mem_rd;
         end
         radio_q <= radio_d;
         mode_ctl_q <= mode_ctl_d;
         pin_sel_q <= pin_sel_d;
         synced_q <= synced_d;
         prog_open_q <= prog_open_d;
         op_strobe_out <= strobe_d;
         radio_state_out <= radio_d;
         prog_ram_open_out <= prog_open_d;
         synced_out <= synced_d;
      end
   end

   // ----------------------------------------
   // Amplifier controls and pin routing
   // ----------------------------------------
   assign amp_ctl.pa = mode_ctl_q[`MODE_PA_BIT] &
                       (radio_q == radio_cmd_pkg::TRANSMIT_STATE); // RQ3
   assign amp_ctl.lna = mode_ctl_q[`MODE_LNA_BIT] &
                        (radio_q == radio_cmd_pkg::RECEIVE_STATE); // RQ4

   amp_pin_router u_router (
      .clk_sys_in(clk_sys_in),
      .nrst_in(nrst_in),
      .ctl_in(amp_ctl),
      .use_test_bus_in(pin_sel_q[`PIN_SEL_BIT]),
      .test_bus_pin_three_out(test_bus_pin_three_out),
      .test_bus_pin_three_oe_out(test_bus_pin_three_oe_out),
      .test_bus_pin_four_out(test_bus_pin_four_out),
      .test_bus_pin_four_oe_out(test_bus_pin_four_oe_out),
      .slow_osc_pin_pos_out(slow_osc_pin_pos_out),
      .slow_osc_pin_pos_oe_out(slow_osc_pin_pos_oe_out),
      .slow_osc_pin_neg_out(slow_osc_pin_neg_out),
      .slow_osc_pin_neg_oe_out(slow_osc_pin_neg_oe_out)
   );

   // ----------------------------------------
   // Host pins: interrupts and serial data
   // ----------------------------------------
   wire sport = mode_ctl_q[`MODE_SPORT_BIT];

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pin_c_meta_q <= 1'b0;
         pin_c_sync_q <= 1'b0;
         packet_mode_interrupt_pin_out <= 1'b0;
         sport_interrupt_pin_out <= 1'b0;
         serial_data_pin_a_out <= 1'b0;
         serial_data_pin_a_oe_out <= 1'b0;
         serial_data_pin_b_out <= 1'b0;
         serial_data_pin_b_oe_out <= 1'b0;
         tx_bit_out <= 1'b0;
      end else begin
         pin_c_meta_q <= serial_data_pin_c_in;
         pin_c_sync_q <= pin_c_meta_q;
         packet_mode_interrupt_pin_out <= irq_req_in & ~sport; // RQ1
         sport_interrupt_pin_out <= irq_req_in & sport; // RQ2
         serial_data_pin_a_out <= sport & rx_bit_in; // RQ2
         serial_data_pin_a_oe_out <= sport; // RQ2
         serial_data_pin_b_out <= sport & bit_clk_in; // RQ2
         serial_data_pin_b_oe_out <= sport; // RQ2
         tx_bit_out <= sport & pin_c_sync_q; // RQ2
      end
   end

endmodule : radio_command_decoder_pa_lna_ctl

// ==== test/radio_cmd_properties.sv ====
// Concurrent checks on the radio command decoder ports
`timescale 1ns/1ps
module radio_cmd_properties (
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   input wire logic ir_cal_fw_loaded_in,
   input wire logic aes_fw_loaded_in,
   input wire logic fec_fw_loaded_in,
   input wire radio_cmd_pkg::radio_state_t radio_state_out,
   input wire radio_cmd_pkg::op_strobe_t op_strobe_out,
   input wire logic synced_out,
   input wire logic test_bus_pin_three_out,
   input wire logic test_bus_pin_four_out,
   input wire logic slow_osc_pin_pos_out,
   input wire logic slow_osc_pin_neg_out,
   input wire logic packet_mode_interrupt_pin_out,
   input wire logic sport_interrupt_pin_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!nrst_in);
   a_strobe_one_cycle: assert property (op_strobe_out != 14'h0000 |=> op_strobe_out == 14'h0000)
      else $error("strobe held longer than one cycle");
   a_reset_to_sleep: assert property (op_strobe_out.full_reset |->
      radio_state_out == radio_cmd_pkg::SLEEP_STATE && !synced_out) else $error("full reset state");
   a_sync_gates_state: assert property (!synced_out |=> $stable(radio_state_out))
      else $error("state moved before sync");
   a_sync_strobe: assert property ($rose(synced_out) |-> op_strobe_out.sync_done)
      else $error("sync flag without sync code");
   a_cipher_gate: assert property (op_strobe_out.encrypt |-> $past(aes_fw_loaded_in))
      else $error("encrypt without cipher firmware");
   a_fec_gate: assert property (op_strobe_out.fec_decode |-> $past(fec_fw_loaded_in))
      else $error("decode without fec firmware");
   a_image_gate: assert property (op_strobe_out.image_cal |-> $past(ir_cal_fw_loaded_in))
      else $error("image cal without firmware");
   a_pa_tx_only: assert property ((radio_state_out != radio_cmd_pkg::TRANSMIT_STATE) [*3]
      |-> !(slow_osc_pin_pos_out || test_bus_pin_three_out)) else $error("pa high off tx");
   a_lna_rx_only: assert property ((radio_state_out != radio_cmd_pkg::RECEIVE_STATE) [*3]
      |-> !(slow_osc_pin_neg_out || test_bus_pin_four_out)) else $error("lna high off rx");
   a_irq_split: assert property (sport_interrupt_pin_out |-> !packet_mode_interrupt_pin_out)
      else $error("both interrupt pins high");
   c_synced: cover property (op_strobe_out.sync_done);
   c_pa_on: cover property (slow_osc_pin_pos_out);
   c_sport_irq: cover property (sport_interrupt_pin_out);
endmodule : radio_cmd_properties
bind radio_command_decoder_pa_lna_ctl radio_cmd_properties u_props (.*);

// ==== test/host_spi_model.sv ====
// Host serial master model, mode 0, MSB first
`timescale 1ns/1ps
module host_spi_model (
   input wire logic clk_sys_in,
   input wire logic miso_in,
   output logic sclk_out = 1'b0,
   output logic mosi_out = 1'b0,
   output logic cs_n_out = 1'b1
);
   logic [7:0] rx_q;
   // Eight system clocks per half period leaves room for the pin synchroniser
   task automatic half();
      repeat (8) @(posedge clk_sys_in);
      #1;
   endtask : half
   task automatic frame(input logic level);
      half();
      cs_n_out = level;
      half();
   endtask : frame
   task automatic xfer(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         mosi_out = b[i];
         half();
         sclk_out = 1'b1;
         rx_q = {rx_q[6:0], miso_in};
         half();
         sclk_out = 1'b0;
      end
      // Idle data line shows the inverse so a stale bit is never mistaken
      mosi_out = ~b[0];
   endtask : xfer
endmodule : host_spi_model

// ==== test/radio_command_decoder_pa_lna_ctl_tb.sv ====
// Self-checking bench for the radio command decoder
`timescale 1ns/1ps
module radio_command_decoder_pa_lna_ctl_tb;
   logic clk_sys_in = 1'b0, nrst_in = 1'b0, irq_req_in = 1'b0, rx_bit_in = 1'b0;
   logic bit_clk_in = 1'b0, serial_data_pin_c_in = 1'b0, spi_sclk_in, spi_mosi_in, spi_cs_n_in;
   logic ir_cal_fw_loaded_in = 1'b0, aes_fw_loaded_in = 1'b0, fec_fw_loaded_in = 1'b0;
   logic spi_miso_out, spi_miso_oe_out, serial_data_pin_a_out, serial_data_pin_a_oe_out;
   logic serial_data_pin_b_out, serial_data_pin_b_oe_out, tx_bit_out, prog_ram_open_out;
   logic packet_mode_interrupt_pin_out, sport_interrupt_pin_out, synced_out;
   logic test_bus_pin_three_out, test_bus_pin_three_oe_out, test_bus_pin_four_out;
   logic test_bus_pin_four_oe_out, slow_osc_pin_pos_out, slow_osc_pin_pos_oe_out;
   logic slow_osc_pin_neg_out, slow_osc_pin_neg_oe_out;
   radio_cmd_pkg::radio_state_t radio_state_out;
   radio_cmd_pkg::op_strobe_t op_strobe_out;
   logic [13:0] seen_q = 14'h0000;
   logic [35:0] e;
   logic [23:0] got;
   int bad_count = 0;
   int total_checks = 0;
   // Firmware, command, expected {synced, program open, strobes, state}
   logic [35:0] tbl [24] = '{36'h0b1000010, 36'h0a2a00010, 36'h0b0800001, 36'h0b1800002,
      36'h0b2800004, 36'h0b5800008, 36'h0ba800010, 36'h0bb900010, 36'h0bc880010,
      36'h0be840010, 36'h0bfc08010, 36'h0c7804010, 36'h0bd800010, 36'h055800010,
      36'h0d0800010, 36'h4bd820010, 36'h2d0802010, 36'h2d1801010, 36'h2d2800810,
      36'h1d1800410, 36'h1d0800210, 36'h1d2800110, 36'h0c8010010, 36'h0a2a00010};
   radio_command_decoder_pa_lna_ctl uut (.*);
   host_spi_model u_host (.clk_sys_in(clk_sys_in), .miso_in(spi_miso_out),
      .sclk_out(spi_sclk_in), .mosi_out(spi_mosi_in), .cs_n_out(spi_cs_n_in));
   initial begin
      forever #2 clk_sys_in = ~clk_sys_in;
   end
   // Strobes last one cycle, so they are gathered here between commands
   always @(posedge clk_sys_in) seen_q <= seen_q | op_strobe_out;
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic cmd(input logic [7:0] c);
      seen_q = 14'h0000;
      u_host.frame(1'b0);
      u_host.xfer(c);
      u_host.frame(1'b1);
      repeat (6) @(posedge clk_sys_in);
      #1;
   endtask : cmd
   task automatic acc(input logic [7:0] op, input logic [7:0] a, input logic [7:0] d);
      u_host.frame(1'b0);
      u_host.xfer(op);
      u_host.xfer(a);
      u_host.xfer(d);
      u_host.frame(1'b1);
   endtask : acc
   task automatic summarize();
      $display("checks=%0d mismatches=%0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : summarize
   initial begin
      #200000;
      bad_count++;
      summarize();
   end
   initial begin
      repeat (5) @(posedge clk_sys_in);
      #1;
      nrst_in = 1'b1;
      chk(24'(radio_state_out), 24'h10);
      acc(8'h39, 8'h39, 8'hff);
      chk(24'(u_host.rx_q), 24'h0);
      acc(8'h19, 8'h00, 8'h5a);
      acc(8'h39, 8'h00, 8'hff);
      chk(24'(u_host.rx_q), 24'h0);
      foreach (tbl[i]) begin
         e = tbl[i];
         {ir_cal_fw_loaded_in, aes_fw_loaded_in, fec_fw_loaded_in} = e[34:32];
         cmd(e[31:24]);
         got = {synced_out, prog_ram_open_out, seen_q, 3'b000, radio_state_out};
         chk(got, e[23:0]);
      end
      acc(8'h19, 8'h1a, 8'h03);
      acc(8'h39, 8'h1a, 8'hff);
      chk(24'(u_host.rx_q), 24'h3);
      cmd(8'hb5);
      got = 24'({slow_osc_pin_pos_out, slow_osc_pin_neg_out, slow_osc_pin_pos_oe_out});
      chk(got, 24'h5);
      cmd(8'hb2);
      chk(24'({slow_osc_pin_pos_out, slow_osc_pin_neg_out}), 24'h1);
      acc(8'h19, 8'h39, 8'h01);
      got = 24'({test_bus_pin_three_out, test_bus_pin_four_out, slow_osc_pin_neg_out});
      chk(got, 24'h2);
      cmd(8'hb5);
      chk(24'({test_bus_pin_three_out, test_bus_pin_four_out}), 24'h2);
      irq_req_in = 1'b1;
      repeat (4) @(posedge clk_sys_in);
      #1;
      got = 24'({packet_mode_interrupt_pin_out, sport_interrupt_pin_out, serial_data_pin_a_oe_out});
      chk(got, 24'h4);
      acc(8'h19, 8'h1a, 8'h04);
      {bit_clk_in, serial_data_pin_c_in, rx_bit_in} = 3'h7;
      repeat (4) @(posedge clk_sys_in);
      #1;
      got = 24'({packet_mode_interrupt_pin_out, sport_interrupt_pin_out, serial_data_pin_a_oe_out,
         serial_data_pin_a_out, serial_data_pin_b_out, tx_bit_out, test_bus_pin_three_out});
      chk(got, 24'h3e);
      summarize();
   end
endmodule : radio_command_decoder_pa_lna_ctl_tb
